// *** design/move_dec_regs.svh ***
// offsets, field codes and constants of the x memory parallel move decoder
// Function
// - short form: bits 13-8 form a 0..63 address; bits 14 and 19 clear.
// - five-bit register codes pick input, accumulator, pointer and offset registers.
// - limited accumulator source is replaced by the 24-bit saturation constant.
// - full accumulator destination: middle word loaded, sign extended, low word cleared.
// - class I does a memory move plus accumulator to y input move.
// - class I memory move accepts seven register modes and absolute; immediate only as a load source.
// - class II uses one address; absolute and immediate modes are illegal.
// - class II stores the accumulator and loads low x input into it.
// - arithmetic operand may be a move source; both sources may match.
// - class I field layout: tag 0001, ff, source acc, y reg, direction.
// - six-bit mode field decodes seven register modes, absolute and immediate.
// - class II layout: tag 0000100, accumulator bit, bits 15-14 clear.
// - any saturation substitution raises the limiting flag.
// - absolute or immediate mode fetches one extension word.
// - bits 7-0 carry the arithmetic operation executed with the move.
// - postincrement accesses at the pointer, then adds one to it.
// - a pointer or offset written by a move is stale for the next instruction.
`ifndef MOVE_DEC_REGS_SVH
`define MOVE_DEC_REGS_SVH
`define CTRL_OFF 4'h0
`define STATUS_OFF 4'h4
`define LASTW_OFF 4'h8
`define STALE_OFF 4'hC
`define CTRL_EN_RST 1'b1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define CLASS1_TAG 4'h1
`define CLASS2_TAG 7'h04
`define SHORT_TAG 2'h1
`define EA_ABS 6'h30
`define EA_IMM 6'h34
`define EA_SPECIAL 3'h6
`define EA_POSTINC 3'h3
`define R_XIN_LO 5'h04
`define R_XIN_HI 5'h05
`define R_YIN_LO 5'h06
`define R_YIN_HI 5'h07
`define R_FIRST_LOW 5'h08
`define R_SECOND_LOW 5'h09
`define R_FIRST_EXT 5'h0A
`define R_SECOND_EXT 5'h0B
`define R_FIRST_MID 5'h0C
`define R_SECOND_MID 5'h0D
`define R_FIRST_FULL 5'h0E
`define R_SECOND_FULL 5'h0F
`define SAT_POS 24'h7FFFFF
`define SAT_NEG 24'h800000
`define LOW_CLEAR 24'h000000
`endif

// *** design/move_dec_pkg.sv ***
// types of the x memory parallel move decoder
package move_dec_pkg;
  typedef enum logic [3:0] {
    FORM_NONE = 4'h1,
    FORM_SHORT = 4'h2,
    FORM_CLASS1 = 4'h4,
    FORM_CLASS2 = 4'h8
  } form_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic [3:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic enable;
    logic limit_sticky;
    logic illegal_sticky;
    logic [23:0] last_word;
    logic dec_valid;
    logic dec_illegal;
    form_t form;
    logic mem_to_reg;
    logic [4:0] mem_sel;
    logic [5:0] ea_field;
    logic [5:0] short_addr;
    logic ext_fetch;
    logic post_inc;
    logic [7:0] alu_op;
    logic mem_wr;
    logic [23:0] mem_wdata;
    logic reg_wr;
    logic [4:0] reg_sel;
    logic [23:0] reg_data;
    logic yreg_wr;
    logic yreg_sel;
    logic [23:0] yreg_data;
    logic acc_wr;
    logic acc_sel;
    logic [55:0] acc_data;
    logic limit;
    logic [15:0] stale_mask;
  } state_t;
endpackage : move_dec_pkg

// *** design/limit_if.sv ***
// accumulator to limiter connection
interface limit_if;
  logic [55:0] acc;
  logic [23:0] value;
  logic limited;
  modport calc (input acc, output value, output limited);
  modport user (output acc, input value, input limited);
endinterface : limit_if

// *** design/acc_limiter.sv ***
// saturating read of one full accumulator
`include "move_dec_regs.svh"
module acc_limiter (
  // accumulator in, limited word out
  limit_if.calc port
);
  // integer part in use when the extension byte differs from the middle sign
  assign port.limited = (port.acc[55:48] != {8{port.acc[47]}});
  // sign of the whole accumulator picks which constant replaces the value
  assign port.value = port.limited ? (port.acc[55] ? `SAT_NEG : `SAT_POS)
                                   : port.acc[47:24];
endmodule : acc_limiter

// *** design/xmem_parallel_move_decoder.sv ***
// x memory parallel move decoder with axi4-lite control registers
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`include "move_dec_regs.svh"
module xmem_parallel_move_decoder (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // instruction from fetch
  input wire logic insn_valid,
  input wire logic [23:0] insn_word,
  // source values, sampled with the instruction
  input wire logic [23:0] xin_lo,
  input wire logic [23:0] xin_hi,
  input wire logic [23:0] yin_lo,
  input wire logic [23:0] yin_hi,
  input wire logic [55:0] first_acc,
  input wire logic [55:0] second_acc,
  input wire logic [15:0] agu_src_value,
  input wire logic [23:0] mem_rdata,
  // decode result and move controls
  output logic dec_valid,
  output logic dec_illegal,
  output logic [3:0] form,
  output logic [7:0] alu_op,
  output logic mem_to_reg,
  output logic [4:0] mem_sel,
  output logic [5:0] ea_field,
  output logic [5:0] short_addr,
  output logic ext_fetch,
  output logic ea_post_inc,
  // memory write
  output logic mem_wr,
  output logic [23:0] mem_wdata,
  // register writes
  output logic reg_wr,
  output logic [4:0] reg_sel,
  output logic [23:0] reg_data,
  output logic yreg_wr,
  output logic yreg_sel,
  output logic [23:0] yreg_data,
  output logic acc_wr,
  output logic acc_sel,
  output logic [55:0] acc_data,
  // condition and pipeline hazard
  output logic limit_flag,
  output logic [15:0] ptr_stale_mask
);
  move_dec_pkg::state_t s_reg;
  move_dec_pkg::state_t s_next;
  logic [23:0] sat_val [2];
  logic sat_hit [2];

  // one limiter per accumulator, so two sources naming the same one agree
  limit_if lim [2] ();
  assign lim[0].acc = first_acc;
  assign lim[1].acc = second_acc;
  generate
    for (genvar i = 0; i < 2; i++) begin : g_lim
      acc_limiter u_lim (
        .port(lim[i])
      );
      assign sat_val[i] = lim[i].value;
      assign sat_hit[i] = lim[i].limited;
    end
  endgenerate

  // value of a source register with its limiting hit in bit 24
  function automatic logic [24:0] read_src(input logic [4:0] code);
    logic [24:0] r;
    r = {1'b0, 8'h00, agu_src_value}; // pointers and offsets zero-extend
    case (code)
      `R_XIN_LO: r = {1'b0, xin_lo};
      `R_XIN_HI: r = {1'b0, xin_hi};
      `R_YIN_LO: r = {1'b0, yin_lo};
      `R_YIN_HI: r = {1'b0, yin_hi};
      `R_FIRST_LOW: r = {1'b0, first_acc[23:0]};
      `R_SECOND_LOW: r = {1'b0, second_acc[23:0]};
      `R_FIRST_EXT: r = {1'b0, {16{first_acc[55]}}, first_acc[55:48]};
      `R_SECOND_EXT: r = {1'b0, {16{second_acc[55]}}, second_acc[55:48]};
      `R_FIRST_MID: r = {1'b0, first_acc[47:24]};
      `R_SECOND_MID: r = {1'b0, second_acc[47:24]};
      `R_FIRST_FULL: r = {sat_hit[0], sat_val[0]};
      `R_SECOND_FULL: r = {sat_hit[1], sat_val[1]};
      default: r = {1'b0, 8'h00, agu_src_value};
    endcase
    return r;
  endfunction : read_src

  // bus slave, register effects and instruction decode
  always_comb begin
    logic [23:0] w;
    logic [4:0] sel;
    logic [5:0] ea;
    logic to_reg;
    logic bad;
    logic [24:0] src;
    logic [24:0] src2;
    logic [15:0] mask;
    move_dec_pkg::form_t fm;
    w = insn_word;
    sel = 5'h00;
    ea = 6'h00;
    to_reg = 1'b0;
    bad = 1'b0;
    src = 25'h0000000;
    src2 = 25'h0000000;
    mask = 16'h0000;
    fm = move_dec_pkg::FORM_NONE;
    s_next = s_reg;
    s_next.dec_valid = 1'b0;
    s_next.dec_illegal = 1'b0;
    s_next.limit = 1'b0;
    s_next.mem_wr = 1'b0;
    s_next.reg_wr = 1'b0;
    s_next.yreg_wr = 1'b0;
    s_next.acc_wr = 1'b0;
    s_next.ext_fetch = 1'b0;

    // address and data are taken independently, in either order
    if (s_reg.awready && awvalid) begin
      s_next.awready = 1'b0;
      s_next.awaddr = awaddr;
    end
    if (s_reg.wready && wvalid) begin
      s_next.wready = 1'b0;
      s_next.wdata = wdata;
      s_next.wstrb = wstrb;
    end
    // both halves held: commit, then answer on the response channel
    if (!s_reg.awready && !s_reg.wready && !s_reg.bvalid) begin
      s_next.bvalid = 1'b1;
      s_next.bresp = `RESP_OKAY;
      case (s_reg.awaddr)
        `CTRL_OFF: begin
          if (s_reg.wstrb[0]) begin
            s_next.enable = s_reg.wdata[0];
          end
        end
        `STATUS_OFF: begin
          if (s_reg.wstrb[0] && s_reg.wdata[0]) begin
            s_next.limit_sticky = 1'b0;
          end
          if (s_reg.wstrb[0] && s_reg.wdata[1]) begin
            s_next.illegal_sticky = 1'b0;
          end
        end
        `LASTW_OFF, `STALE_OFF: s_next.bresp = `RESP_OKAY; // read only
        default: s_next.bresp = `RESP_SLVERR;
      endcase
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
      s_next.awready = 1'b1;
      s_next.wready = 1'b1;
    end

    // read answers on the same edge that takes the address
    if (s_reg.arready && arvalid) begin
      s_next.arready = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rresp = `RESP_OKAY;
      case (araddr)
        `CTRL_OFF: s_next.rdata = {31'h00000000, s_reg.enable};
        `STATUS_OFF: s_next.rdata = {30'h00000000, s_reg.illegal_sticky, s_reg.limit_sticky};
        `LASTW_OFF: s_next.rdata = {8'h00, s_reg.last_word};
        `STALE_OFF: s_next.rdata = {16'h0000, s_reg.stale_mask};
        default: begin
          s_next.rdata = 32'h00000000;
          s_next.rresp = `RESP_SLVERR;
        end
      endcase
    end
    if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
      s_next.arready = 1'b1;
    end

    // classify the word; y memory and long x forms are left to other decoders
    if (w[23:20] == `CLASS1_TAG && !w[14]) begin
      fm = move_dec_pkg::FORM_CLASS1;
    end else if (w[23:17] == `CLASS2_TAG && w[15:14] == 2'h0) begin
      fm = move_dec_pkg::FORM_CLASS2;
    end else if (w[23:22] == `SHORT_TAG && !w[19] && !w[14]) begin
      fm = move_dec_pkg::FORM_SHORT;
    end
    unique case (fm)
      move_dec_pkg::FORM_SHORT: begin
        sel = {w[21:20], w[18:16]};
        to_reg = w[15];
      end
      move_dec_pkg::FORM_CLASS1: begin
        ea = w[13:8];
        to_reg = w[15];
        case (w[19:18])
          2'h0: sel = `R_XIN_LO;
          2'h1: sel = `R_XIN_HI;
          2'h2: sel = `R_FIRST_FULL;
          default: sel = `R_SECOND_FULL;
        endcase
        // every mode passes except reserved 110 codes and a store to immediate
        bad = (ea[5:3] == `EA_SPECIAL && ea != `EA_ABS && ea != `EA_IMM) ||
              (ea == `EA_IMM && !w[15]);
      end
      move_dec_pkg::FORM_CLASS2: begin
        ea = w[13:8];
        sel = w[16] ? `R_SECOND_FULL : `R_FIRST_FULL;
        to_reg = 1'b0;
        bad = (ea[5:3] == `EA_SPECIAL);
      end
      move_dec_pkg::FORM_NONE: bad = 1'b0;
    endcase

    // sources read from the present inputs, destinations written after the edge
    if (insn_valid && s_reg.enable && fm != move_dec_pkg::FORM_NONE) begin
      src = read_src(sel);
      src2 = w[17] ? {sat_hit[1], sat_val[1]} : {sat_hit[0], sat_val[0]};
      s_next.last_word = w;
      s_next.form = fm;
      s_next.alu_op = w[7:0];
      s_next.mem_sel = sel;
      s_next.mem_to_reg = to_reg;
      s_next.ea_field = ea;
      s_next.short_addr = w[13:8];
      s_next.post_inc = (fm != move_dec_pkg::FORM_SHORT) && (ea[5:3] == `EA_POSTINC);
      if (bad) begin
        s_next.dec_illegal = 1'b1;
        s_next.illegal_sticky = 1'b1;
        s_next.post_inc = 1'b0;
      end else begin
        s_next.dec_valid = 1'b1;
        s_next.ext_fetch = (fm != move_dec_pkg::FORM_SHORT) &&
                           (ea == `EA_ABS || ea == `EA_IMM);
        if (to_reg) begin
          if (sel == `R_FIRST_FULL || sel == `R_SECOND_FULL) begin
            s_next.acc_wr = 1'b1;
            s_next.acc_sel = sel[0];
            s_next.acc_data = {{8{mem_rdata[23]}}, mem_rdata, `LOW_CLEAR};
          end else begin
            s_next.reg_wr = 1'b1;
            s_next.reg_sel = sel;
            s_next.reg_data = mem_rdata;
            if (sel[4]) begin
              mask[sel[3:0]] = 1'b1;
            end
          end
        end else begin
          s_next.mem_wr = 1'b1;
          s_next.mem_wdata = src[23:0];
          s_next.limit = src[24];
        end
        if (fm == move_dec_pkg::FORM_CLASS1) begin
          s_next.yreg_wr = 1'b1;
          s_next.yreg_sel = w[16];
          s_next.yreg_data = src2[23:0];
          s_next.limit = s_next.limit | src2[24];
        end
        if (fm == move_dec_pkg::FORM_CLASS2) begin
          s_next.acc_wr = 1'b1;
          s_next.acc_sel = w[16];
          s_next.acc_data = {{8{xin_lo[23]}}, xin_lo, `LOW_CLEAR};
        end
      end
      // the mask lasts exactly until the following instruction is decoded
      s_next.stale_mask = mask;
      // a new hit beats a clear arriving in the same cycle
      s_next.limit_sticky = s_next.limit_sticky | s_next.limit;
    end
  end

  // state register, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
      s_reg.enable <= `CTRL_EN_RST;
      s_reg.form <= move_dec_pkg::FORM_NONE;
    end else begin
      s_reg <= s_next;
    end
  end

  // every output is a state field
  assign awready = s_reg.awready;
  assign wready = s_reg.wready;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign arready = s_reg.arready;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
  assign dec_valid = s_reg.dec_valid;
  assign dec_illegal = s_reg.dec_illegal;
  assign form = s_reg.form;
  assign alu_op = s_reg.alu_op;
  assign mem_to_reg = s_reg.mem_to_reg;
  assign mem_sel = s_reg.mem_sel;
  assign ea_field = s_reg.ea_field;
  assign short_addr = s_reg.short_addr;
  assign ext_fetch = s_reg.ext_fetch;
  assign ea_post_inc = s_reg.post_inc;
  assign mem_wr = s_reg.mem_wr;
  assign mem_wdata = s_reg.mem_wdata;
  assign reg_wr = s_reg.reg_wr;
  assign reg_sel = s_reg.reg_sel;
  assign reg_data = s_reg.reg_data;
  assign yreg_wr = s_reg.yreg_wr;
  assign yreg_sel = s_reg.yreg_sel;
  assign yreg_data = s_reg.yreg_data;
  assign acc_wr = s_reg.acc_wr;
  assign acc_sel = s_reg.acc_sel;
  assign acc_data = s_reg.acc_data;
  assign limit_flag = s_reg.limit;
  assign ptr_stale_mask = s_reg.stale_mask;
endmodule : xmem_parallel_move_decoder

// *** verif/move_dec_sva.sv ***
// concurrent checks on the ports of the x memory parallel move decoder
module move_dec_sva (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // instruction and sources
  input wire logic [23:0] insn_word,
  input wire logic [23:0] xin_lo,
  // decode results
  input wire logic dec_valid,
  input wire logic [3:0] form,
  input wire logic [7:0] alu_op,
  input wire logic mem_to_reg,
  input wire logic [5:0] short_addr,
  input wire logic ext_fetch,
  // move strobes and data
  input wire logic mem_wr,
  input wire logic [23:0] mem_wdata,
  input wire logic yreg_wr,
  input wire logic acc_wr,
  input wire logic [55:0] acc_data,
  input wire logic limit_flag
);
  timeunit 1ns;
  timeprecision 100ps;

  // every check is on the single core clock, masked while reset is low
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_alu;
    dec_valid |-> alu_op == $past(insn_word[7:0]);
  endproperty
  a_alu: assert property (p_alu)
    else $error("alu operation byte not passed through");
  property p_short;
    dec_valid && form == 4'h2 |-> short_addr == $past(insn_word[13:8]);
  endproperty
  a_short: assert property (p_short)
    else $error("short address differs from instruction bits");
  property p_dir;
    dec_valid && form == 4'h4 |-> mem_to_reg == $past(insn_word[15]) && mem_wr == !mem_to_reg;
  endproperty
  a_dir: assert property (p_dir)
    else $error("move direction wrong");
  property p_ymove;
    dec_valid && form == 4'h4 |-> yreg_wr;
  endproperty
  a_ymove: assert property (p_ymove)
    else $error("class one second move missing");
  property p_ext;
    ext_fetch |-> $past(insn_word[13:8]) inside {6'h30, 6'h34};
  endproperty
  a_ext: assert property (p_ext)
    else $error("extension fetch without absolute or immediate mode");
  property p_accdst;
    acc_wr |-> acc_data[23:0] == 24'h000000 && acc_data[55:48] == {8{acc_data[47]}};
  endproperty
  a_accdst: assert property (p_accdst)
    else $error("accumulator load not extended or low word not cleared");
  property p_cls2;
    dec_valid && form == 4'h8 |-> mem_wr && acc_wr && acc_data[47:24] == $past(xin_lo);
  endproperty
  a_cls2: assert property (p_cls2)
    else $error("class two store and load not both done");
  // class two stores an accumulator with no second move, so a limit there must show in the data
  property p_sat;
    mem_wr && form == 4'h8 && limit_flag |-> mem_wdata inside {24'h7FFFFF, 24'h800000};
  endproperty
  a_sat: assert property (p_sat)
    else $error("limit flagged without saturation constant");
endmodule : move_dec_sva

bind xmem_parallel_move_decoder move_dec_sva sva_u (
  .aclk, .aresetn, .insn_word, .xin_lo, .dec_valid, .form, .alu_op, .mem_to_reg,
  .short_addr, .ext_fetch, .mem_wr, .mem_wdata, .yreg_wr, .acc_wr, .acc_data, .limit_flag
);

// *** verif/fetch_alu_model.sv ***
// fetch side and data alu register file model feeding the decoder
module fetch_alu_model (
  // clock
  input wire logic aclk,
  // instruction offer
  output logic insn_valid,
  output logic [23:0] insn_word,
  output logic [23:0] mem_rdata,
  // source registers
  output logic [23:0] xin_lo,
  output logic [23:0] xin_hi,
  output logic [23:0] yin_lo,
  output logic [23:0] yin_hi,
  output logic [55:0] first_acc,
  output logic [55:0] second_acc,
  output logic [15:0] agu_src_value
);
  timeunit 1ns;
  timeprecision 100ps;

  // fixed register contents; both accumulators have their integer part in use
  initial begin
    insn_valid = 1'b0;
    insn_word = 24'h000000;
    mem_rdata = 24'h000000;
    xin_lo = 24'h400000;
    xin_hi = 24'h111111;
    yin_lo = 24'h0ABCDE;
    yin_hi = 24'h222222;
    first_acc = 56'h00_800000_000000;
    second_acc = 56'hFF_7FFFFF_000000;
    agu_src_value = 16'h1234;
  end

  // offers a word for n cycles; callers never name the alu destination as move target
  task automatic send(input logic [23:0] w, input logic [23:0] m, input int n);
    @(posedge aclk);
    insn_valid <= 1'b1;
    insn_word <= w;
    mem_rdata <= m;
    repeat (n) @(posedge aclk);
    insn_valid <= 1'b0;
    // a released word must not keep looking valid
    mem_rdata <= ~m;
  endtask : send
endmodule : fetch_alu_model

// *** verif/xmem_parallel_move_decoder_tb.sv ***
// self-checking bench for the x memory parallel move decoder
module xmem_parallel_move_decoder_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awready, wready, bvalid, arready, rvalid, insn_valid, dec_valid, dec_illegal;
  logic mem_to_reg, ext_fetch, ea_post_inc, mem_wr, reg_wr, yreg_wr, yreg_sel;
  logic acc_wr, acc_sel, limit_flag;
  logic [1:0] bresp, rresp, rsp;
  logic [3:0] form;
  logic [4:0] mem_sel, reg_sel;
  logic [5:0] ea_field, short_addr;
  logic [7:0] alu_op;
  logic [15:0] agu_src_value, ptr_stale_mask;
  logic [23:0] insn_word, xin_lo, xin_hi, yin_lo, yin_hi, mem_rdata;
  logic [23:0] mem_wdata, reg_data, yreg_data;
  logic [55:0] first_acc, second_acc, acc_data;
  int fails = 0, num_checks = 0, cyc = 0, nv = 0, n0;

  xmem_parallel_move_decoder dut_u (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .insn_valid, .insn_word, .xin_lo, .xin_hi, .yin_lo, .yin_hi, .first_acc,
    .second_acc, .agu_src_value, .mem_rdata, .dec_valid, .dec_illegal, .form, .alu_op,
    .mem_to_reg, .mem_sel, .ea_field, .short_addr, .ext_fetch, .ea_post_inc, .mem_wr,
    .mem_wdata, .reg_wr, .reg_sel, .reg_data, .yreg_wr, .yreg_sel, .yreg_data, .acc_wr,
    .acc_sel, .acc_data, .limit_flag, .ptr_stale_mask
  );
  fetch_alu_model fam_u (
    .aclk, .insn_valid, .insn_word, .mem_rdata, .xin_lo, .xin_hi, .yin_lo, .yin_hi,
    .first_acc, .second_acc, .agu_src_value
  );

  always #5 aclk = ~aclk;

  // decode pulse counter and hang guard; the whole run needs under a hundred cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (dec_valid === 1'b1) nv <= nv + 1;
    if (cyc == 3000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [55:0] s, input logic [55:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  // write with address and data offered together, response taken in rsp
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [3:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : rdr

  // sends one word and lets the registered outputs settle
  task automatic go(input logic [23:0] w, input logic [23:0] m);
    fam_u.send(w, m, 1);
    #1;
  endtask : go

  task automatic t_regs;
    rdr(4'h0);
    chk("ctrl", rd, 32'h1);
    rdr(4'h4);
    chk("status", rd, 32'h0);
    rdr(4'h6);
    chk("unmapped", rsp, 2'h2);
    wr(4'h6, 32'h0);
    chk("wr unmapped", rsp, 2'h2);
  endtask : t_regs

  task automatic t_short;
    go(24'h45BF00, 24'h13579B);
    chk("short form", form, 4'h2);
    chk("short addr", short_addr, 6'h3F);
    chk("reg wr", reg_wr, 1'b1);
    chk("reg sel", reg_sel, 5'h05);
    chk("reg data", reg_data, 24'h13579B);
    go(24'h460012, 24'h0);
    chk("store", mem_wr, 1'b1);
    chk("store data", mem_wdata, 24'h0ABCDE);
    // offset register source is zero-extended from 16 bits
    go(24'h720100, 24'h0);
    chk("offset store", mem_wdata, 24'h001234);
    go(24'h570200, 24'h0);
    chk("short sat", mem_wdata, 24'h800000);
    chk("short limit", limit_flag, 1'b1);
    go(24'h638500, 24'h000777);
    chk("stale", ptr_stale_mask, 16'h0008);
    rdr(4'hC);
    chk("stale reg", rd, 32'h8);
  endtask : t_short

  task automatic t_class1;
    go(24'h18195A, 24'h0);
    chk("c1 store", mem_wdata, 24'h7FFFFF);
    chk("c1 y data", yreg_data, 24'h7FFFFF);
    chk("c1 y sel", yreg_sel, 1'b0);
    chk("c1 limit", limit_flag, 1'b1);
    chk("c1 postinc", ea_post_inc, 1'b1);
    chk("c1 alu", alu_op, 8'h5A);
    chk("c1 mem sel", mem_sel, 5'h0E);
    chk("c1 ea", ea_field, 6'h19);
    rdr(4'h4);
    chk("limit sticky", rd[0], 1'b1);
    wr(4'h4, 32'h1);
    chk("wr resp", rsp, 2'h0);
    rdr(4'h4);
    chk("sticky clear", rd[0], 1'b0);
    go(24'h19B400, 24'h923456);
    chk("c1 acc", acc_data, 56'hFF_923456_000000);
    chk("c1 ext", ext_fetch, 1'b1);
    chk("c1 y1", yreg_sel, 1'b1);
    chk("c1 old src", yreg_data, 24'h7FFFFF);
    go(24'h10A000, 24'h00C0DE);
    chk("c1 x0 sel", reg_sel, 5'h04);
    chk("c1 x0 data", reg_data, 24'h00C0DE);
    // second accumulator feeds the y move while x0 goes to an absolute address
    go(24'h12303C, 24'h0);
    chk("c1 s2 second", yreg_data, 24'h800000);
    chk("c1 abs", ext_fetch, 1'b1);
    chk("c1 x0 store", mem_wdata, 24'h400000);
    go(24'h183400, 24'h0);
    chk("imm store", {dec_illegal, mem_wr}, 2'b10);
    rdr(4'h4);
    chk("illegal sticky", rd[1], 1'b1);
  endtask : t_class1

  task automatic t_class2;
    n0 = nv;
    fam_u.send(24'h091900, 24'h0, 2);
    #1;
    chk("c2 store", mem_wdata, 24'h800000);
    chk("c2 acc sel", acc_sel, 1'b1);
    chk("c2 acc", acc_data, 56'h00_400000_000000);
    @(posedge aclk);
    #1;
    chk("c2 pulses", nv - n0, 2);
    go(24'h093000, 24'h0);
    chk("c2 abs", {dec_illegal, acc_wr}, 2'b10);
    rdr(4'h8);
    chk("last word", rd, 32'h00093000);
    wr(4'h0, 32'h0);
    go(24'h091900, 24'h0);
    chk("disabled", dec_valid, 1'b0);
    wr(4'h0, 32'h1);
  endtask : t_class2

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_short();
    t_class1();
    t_class2();
    report_and_stop();
  end
endmodule : xmem_parallel_move_decoder_tb
